// [src/epi_top.sv]
`timescale 1ns/1ps
`default_nettype none

module epi_top
  import epi_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // external request pin, raw and asynchronous
  input wire logic ext_request_pin_i,
  // pin control bits
  input wire logic ext_request_pin_enable_i,
  input wire logic edge_polarity_select_i,
  input wire logic detect_mode_select_i,
  input wire logic pull_device_disable_i,
  input wire logic pin_interrupt_enable_i,
  input wire logic flag_acknowledge_i,
  input wire logic stop_mode_i,
  // other interrupt sources
  input wire logic [VEC_COUNT-1:0] source_flag_i,
  input wire logic [VEC_COUNT-1:0] source_enable_i,
  // cpu side
  input wire logic software_trap_i,
  input wire logic instr_boundary_i,
  input wire logic mask_clear_i,
  input wire logic mask_set_i,
  input wire logic [15:0] cpu_pc_i,
  input wire logic [15:0] cpu_sp_i,
  input wire logic [7:0] cpu_x_i,
  input wire logic [7:0] cpu_a_i,
  input wire logic [7:0] cpu_ccr_i,
  input wire logic [7:0] mem_rdata_i,
  // pin status and pad control
  output logic pin_event_flag_o,
  output logic pin_irq_o,
  output logic pull_enable_o,
  output logic pull_up_o,
  output logic branch_if_pin_high_o,
  output logic branch_if_pin_low_o,
  output logic wake_o,
  // vectoring outputs
  output logic global_mask_o,
  output logic entry_busy_o,
  output logic mem_write_o,
  output logic mem_read_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic [VEC_W-1:0] vector_number_o,
  output logic [15:0] handler_addr_o,
  output logic handler_valid_o
);

  // whole block state
  typedef struct packed
  {
    logic pin_meta;
    logic pin_sync;
    logic asserted_prev;
    logic flag;
    logic irq;
    logic pull_en;
    logic pull_up;
    logic pin_high;
    logic pin_low;
    logic wake;
    logic mask;
    logic trap;
    epi_state_t state;
    logic [2:0] step;
    logic [VEC_W-1:0] vec;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] x;
    logic [7:0] a;
    logic [7:0] condition_code_register;
    logic [7:0] vec_hi;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] handler;
    logic handler_valid;
    logic busy;
  } epi_regs_t;

  // controls clear, mask set, reset vector fetch armed
  localparam epi_regs_t REGS_RESET = '{
    state: ST_BOOT,
    asserted_prev: 1'b1, // no false edge from the cleared pin copy
    mask: 1'b1,
    busy: 1'b1,
    default: '0
  };

  logic rst_meta_q;
  logic rst_sync_q;
  epi_regs_t q;
  epi_regs_t d;
  logic [VEC_COUNT-1:0] pending;
  logic req_found;
  logic [VEC_W-1:0] req_number;
  logic asserted_now;
  logic edge_seen;
  logic level_hold;

  // reset release is synchronised, assertion stays asynchronous
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // pin detection terms, all on the synchronised copy
  always_comb
  begin
    // polarity 0 means falling edge / low level, 1 rising / high
    asserted_now = edge_polarity_select_i ? q.pin_sync
                                          : ~q.pin_sync; // RQ2
    edge_seen = ext_request_pin_enable_i & asserted_now
                & ~q.asserted_prev; // RQ1 RQ11
    level_hold = ext_request_pin_enable_i & detect_mode_select_i
                 & asserted_now; // RQ3 RQ12
  end

  // requests presented to the priority encoder
  always_comb
  begin
    // maskable sources need their own enable and a clear global mask
    pending = source_flag_i & source_enable_i
              & {VEC_COUNT{~q.mask}}; // RQ13
    pending[VEC_PIN] = q.irq & ~q.mask; // RQ4
    pending[VEC_TRAP] = q.trap; // trap ignores the mask
    pending[VEC_RESET] = 1'b0; // reset is never a request
  end

  epi_prio
  #(
    .N(VEC_COUNT),
    .W(VEC_W)
  )
  u_prio
  (
    .pending_i(pending),
    .found_o(req_found),
    .number_o(req_number)
  );

  // next state of the whole block
  always_comb
  begin
    d = q;

    // two-stage synchroniser; the first stage feeds only the second
    d.pin_meta = ext_request_pin_i; // RQ8
    d.pin_sync = q.pin_meta;
    d.asserted_prev = asserted_now;

    // set wins over acknowledge, level mode refuses the clear
    d.flag = edge_seen | level_hold
             | (q.flag & ~flag_acknowledge_i); // RQ4 RQ12 RQ19
    d.irq = d.flag & pin_interrupt_enable_i; // RQ4 RQ13

    // pull toward the deasserted level
    d.pull_en = ext_request_pin_enable_i
                & ~pull_device_disable_i; // RQ5 RQ7
    d.pull_up = ~edge_polarity_select_i; // RQ6

    // branch conditions see the pin only while it is the request input
    d.pin_high = ext_request_pin_enable_i & q.pin_sync; // RQ10
    d.pin_low = ext_request_pin_enable_i & ~q.pin_sync; // RQ10

    // wake request while the core sleeps; level based so it survives
    // a stalled clock and needs no edge history from before the stop
    d.wake = stop_mode_i & ext_request_pin_enable_i
             & asserted_now; // RQ9

    // software trap stays pending until its entry starts
    d.trap = q.trap | software_trap_i;

    // software mask control only between entries
    if (q.state == ST_IDLE)
    begin
      if (mask_set_i)
      begin
        d.mask = 1'b1;
      end
      else if (mask_clear_i)
      begin
        d.mask = 1'b0;
      end
    end

    // single-cycle strobes default low
    d.wr = 1'b0;
    d.rd = 1'b0;
    d.handler_valid = 1'b0;

    case (q.state)
      ST_BOOT:
      begin
        // first action after reset: fetch the shared reset vector
        d.vec = VEC_RESET;
        d.addr = epi_vec_addr(VEC_RESET); // RQ17
        d.rd = 1'b1;
        d.busy = 1'b1;
        d.state = ST_VEC_HI;
      end

      ST_IDLE:
      begin
        // entry only at an instruction boundary
        if (instr_boundary_i && req_found) // RQ14
        begin
          d.vec = req_number; // RQ16
          d.pc = cpu_pc_i;
          d.sp = cpu_sp_i;
          d.x = cpu_x_i;
          d.a = cpu_a_i;
          d.condition_code_register = cpu_ccr_i;
          if (req_number == VEC_TRAP)
          begin
            d.trap = software_trap_i; // a new trap is kept
          end
          // first push goes out right away
          d.addr = cpu_sp_i;
          d.wdata = cpu_pc_i[7:0]; // RQ14
          d.wr = 1'b1;
          d.step = PUSH_PCH;
          d.busy = 1'b1;
          d.state = ST_PUSH;
        end
      end

      ST_PUSH:
      begin
        // stack grows downward, one byte a cycle
        d.addr = q.addr - 16'h0001;
        d.wr = 1'b1;
        d.step = q.step + 3'h1;
        case (q.step)
          PUSH_PCH: d.wdata = q.pc[15:8];
          PUSH_X: d.wdata = q.x;
          PUSH_A: d.wdata = q.a;
          PUSH_CCR: d.wdata = q.condition_code_register; // stacked before the mask is set
          default: d.wdata = q.condition_code_register;
        endcase
        if (q.step == PUSH_CCR)
        begin
          d.state = ST_VEC_HI;
        end
        // last push done: mask, then address the vector
        if (q.step == PUSH_CCR + 3'h1)
        begin
          d.wr = 1'b0;
          d.step = PUSH_PCL;
          d.mask = 1'b1; // RQ14
          d.addr = epi_vec_addr(q.vec); // RQ17
          d.rd = 1'b1;
        end
      end

      ST_VEC_HI:
      begin
        if (q.rd)
        begin
          // high byte is taken in the same cycle as its read strobe
          d.vec_hi = mem_rdata_i; // RQ15
          d.addr = q.addr + 16'h0001;
          d.rd = 1'b1;
          d.state = ST_VEC_LO;
        end
        else
        begin
          // finishing the last push before the read goes out
          d.wr = 1'b0;
          d.step = PUSH_PCL;
          d.mask = 1'b1; // RQ14
          d.addr = epi_vec_addr(q.vec); // RQ17
          d.rd = 1'b1;
        end
      end

      ST_VEC_LO:
      begin
        // low byte at the next higher address completes the handler
        d.handler = {q.vec_hi, mem_rdata_i}; // RQ15
        d.handler_valid = 1'b1;
        d.busy = 1'b0;
        d.mask = 1'b1; // RQ18
        d.state = ST_IDLE;
      end

      default:
      begin
        d.state = ST_IDLE;
        d.busy = 1'b0;
      end
    endcase
  end

  // the one register bank of the block
  always_ff @(posedge ref_clk_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      q <= REGS_RESET; // RQ18 RQ19
    end
    else
    begin
      q <= d;
    end
  end

  // every output straight from the register bank
  assign pin_event_flag_o = q.flag;
  assign pin_irq_o = q.irq;
  assign pull_enable_o = q.pull_en;
  assign pull_up_o = q.pull_up;
  assign branch_if_pin_high_o = q.pin_high;
  assign branch_if_pin_low_o = q.pin_low;
  assign wake_o = q.wake;
  assign global_mask_o = q.mask;
  assign entry_busy_o = q.busy;
  assign mem_write_o = q.wr;
  assign mem_read_o = q.rd;
  assign mem_addr_o = q.addr;
  assign mem_wdata_o = q.wdata;
  assign vector_number_o = q.vec;
  assign handler_addr_o = q.handler;
  assign handler_valid_o = q.handler_valid;

endmodule

`default_nettype wire

// [src/epi_pkg.sv]
// Functional notes
// [RQ1] pin events only while pin enable is 1
// [RQ2] software picks asserted level and edge polarity
// [RQ3] software picks edge-only or edge-and-level detection
// [RQ4] events always set flag; request needs enable
// [RQ5] pull device on when enabled, not disabled
// [RQ6] pull toward deasserted level: up or down
// [RQ7] pull disable bit 1 turns pull device off
// [RQ8] bus-clock synchronous logic watches the pin
// [RQ9] stop mode uses separate wake path
// [RQ10] pin level offered to branch-on-pin instructions
// [RQ11] edge is deasserted-to-asserted move, sets flag
// [RQ12] level mode holds flag while pin asserted
// [RQ13] sources forward requests only when enabled
// [RQ14] finish instruction, stack five bytes, mask, vector
// [RQ15] vector high byte first, low byte next
// [RQ16] fixed priority, lower vector number wins
// [RQ17] pin vector 3, reset vector 0 addresses
// [RQ18] global mask set after any reset
// [RQ19] acknowledge clears flag; controls reset to zero
package epi_pkg;

  localparam int VEC_COUNT = 32;
  localparam int VEC_W = 5;

  // fixed vector numbers of the sources handled here
  localparam logic [VEC_W-1:0] VEC_RESET = 5'h00;
  localparam logic [VEC_W-1:0] VEC_TRAP = 5'h01;
  localparam logic [VEC_W-1:0] VEC_LOWV = 5'h02;
  localparam logic [VEC_W-1:0] VEC_PIN = 5'h03;

  // vector 0 sits at the top word, each lower priority two bytes down
  localparam logic [15:0] VEC_TOP_ADDR = 16'hfffe;

  // stacking order, one byte per step
  localparam logic [2:0] PUSH_PCL = 3'h0;
  localparam logic [2:0] PUSH_PCH = 3'h1;
  localparam logic [2:0] PUSH_X = 3'h2;
  localparam logic [2:0] PUSH_A = 3'h3;
  localparam logic [2:0] PUSH_CCR = 3'h4;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_PUSH = 5'h02,
    ST_VEC_HI = 5'h04,
    ST_VEC_LO = 5'h08,
    ST_BOOT = 5'h10
  } epi_state_t;

  // address of the high byte of a vector
  function automatic logic [15:0] epi_vec_addr(input logic [VEC_W-1:0] n);
    epi_vec_addr = VEC_TOP_ADDR - {10'h000, n, 1'b0};
  endfunction

endpackage

// [src/epi_prio.sv]
`timescale 1ns/1ps
`default_nettype none

// pure priority encoder; the caller registers the result
module epi_prio
#(
  parameter int N = 32,
  parameter int W = 5
)
(
  input wire logic [N-1:0] pending_i,
  output logic found_o,
  output logic [W-1:0] number_o
);

  // scan downward so the lowest pending number is the last one kept
  always_comb
  begin
    found_o = 1'b0;
    number_o = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (pending_i[i])
      begin
        found_o = 1'b1;
        number_o = W'(i); // RQ16
      end
    end
  end

endmodule

`default_nettype wire

// [sim/epi_checker.sv]
`timescale 1ns/1ps
`default_nettype none

// watches the pin path and the entry sequence from the top ports only
module epi_checker
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic ext_request_pin_enable_i,
  input wire logic edge_polarity_select_i,
  input wire logic pull_device_disable_i,
  input wire logic flag_acknowledge_i,
  input wire logic stop_mode_i,
  input wire logic [15:0] cpu_pc_i,
  input wire logic [15:0] cpu_sp_i,
  input wire logic [7:0] cpu_x_i,
  input wire logic [7:0] cpu_a_i,
  input wire logic [7:0] cpu_ccr_i,
  input wire logic pin_event_flag_o,
  input wire logic pin_irq_o,
  input wire logic pull_enable_o,
  input wire logic pull_up_o,
  input wire logic branch_if_pin_high_o,
  input wire logic branch_if_pin_low_o,
  input wire logic wake_o,
  input wire logic global_mask_o,
  input wire logic mem_write_o,
  input wire logic mem_read_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic [4:0] vector_number_o,
  input wire logic handler_valid_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  // five stack writes, then the two vector byte reads, then the result
  sequence s_stack;
    mem_write_o [*5];
  endsequence
  sequence s_fetch;
    mem_read_o [*2] ##1 handler_valid_o;
  endsequence
  // bytes two to five of the frame, against the values taken at entry
  sequence s_frame_rest;
    mem_wdata_o == $past(cpu_pc_i[15:8], 2) ##1
    mem_wdata_o == $past(cpu_x_i, 3) ##1
    mem_wdata_o == $past(cpu_a_i, 4) ##1
    mem_wdata_o == $past(cpu_ccr_i, 5);
  endsequence

  a_flag_needs_en: assert property ($rose(pin_event_flag_o) |->
    $past(ext_request_pin_enable_i)) else $error("flag set while off");
  a_irq_with_flag: assert property (pin_irq_o |-> pin_event_flag_o)
    else $error("request without flag");
  a_flag_ack_only: assert property ($fell(pin_event_flag_o) |->
    $past(flag_acknowledge_i)) else $error("flag fell without ack");
  a_pull_on_state: assert property (pull_enable_o ==
    $past(ext_request_pin_enable_i && !pull_device_disable_i))
    else $error("pull enable wrong");
  a_pull_dir_pol: assert property (pull_enable_o |->
    pull_up_o == !$past(edge_polarity_select_i)) else $error("pull dir");
  a_branch_needs_en: assert property ((branch_if_pin_high_o ||
    branch_if_pin_low_o) |-> $past(ext_request_pin_enable_i))
    else $error("branch level while off");
  a_wake_in_stop: assert property (wake_o |->
    $past(stop_mode_i && ext_request_pin_enable_i)) else $error("wake");
  a_entry_run: assert property ($rose(mem_write_o) |->
    s_stack ##1 s_fetch) else $error("entry sequence broken");
  a_frame_first: assert property ($rose(mem_write_o) |->
    mem_addr_o == $past(cpu_sp_i) && mem_wdata_o == $past(cpu_pc_i[7:0]))
    else $error("first stacked byte wrong");
  a_stack_bytes: assert property ($rose(mem_write_o) |=>
    s_frame_rest) else $error("stacked byte wrong");
  a_stack_down: assert property (mem_write_o && $past(mem_write_o) |->
    mem_addr_o == $past(mem_addr_o) - 16'h0001) else $error("stack addr");
  a_vec_pair: assert property ($rose(mem_read_o) |-> !mem_addr_o[0]
    ##1 mem_addr_o == $past(mem_addr_o) + 16'h0001) else $error("pair");
  a_vec_addr: assert property ($rose(mem_read_o) |->
    mem_addr_o == 16'hfffe - {10'h000, vector_number_o, 1'b0} &&
    global_mask_o) else $error("vector address or mask");
endmodule

bind epi_top epi_checker u_epi_checker (.*);

`default_nettype wire

// [sim/epi_partner.sv]
`timescale 1ns/1ps
`default_nettype none

// vector memory and the pin wire with its pull device
module epi_partner
(
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic drv_en_i,
  input wire logic drv_val_i,
  input wire logic pull_en_i,
  input wire logic pull_up_i,
  output logic [7:0] rdata_o,
  output logic pin_o
);
  logic [7:0] hold_q = 8'h00;
  logic held_q = 1'b0;
  logic flt_q = 1'b0;

  // data holds one cycle after the strobe, then turns to junk
  always_ff @(posedge clk_i)
  begin
    flt_q <= !flt_q;
    held_q <= rd_i;
    if (rd_i)
      hold_q <= addr_i[7:0] ^ 8'h3c;
    else if (held_q)
      hold_q <= ~hold_q;
  end
  assign rdata_o = rd_i ? (addr_i[7:0] ^ 8'h3c) : hold_q;
  // a floating pin toggles so no level is assumed
  assign pin_o = drv_en_i ? drv_val_i : (pull_en_i ? pull_up_i : flt_q);
endmodule

`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import epi_pkg::*;
  logic ref_clk_i = 0, reset_n_i = 0, ext_request_pin_i, drv_en = 0;
  logic drv_val = 0, ext_request_pin_enable_i = 0, edge_polarity_select_i = 0;
  logic detect_mode_select_i = 0, pull_device_disable_i = 0;
  logic pin_interrupt_enable_i = 0, flag_acknowledge_i = 0, stop_mode_i = 0;
  logic [31:0] source_flag_i = 32'h0, source_enable_i = 32'h0;
  logic software_trap_i = 0, instr_boundary_i = 0, mask_clear_i = 0;
  logic mask_set_i = 0;
  logic [15:0] cpu_pc_i = 16'h1234, cpu_sp_i = 16'h00ff;
  logic [7:0] cpu_x_i = 8'h5a, cpu_a_i = 8'ha5, cpu_ccr_i = 8'h60;
  logic [7:0] mem_rdata_i, mem_wdata_o;
  logic pin_event_flag_o, pin_irq_o, pull_enable_o, pull_up_o, wake_o;
  logic branch_if_pin_high_o, branch_if_pin_low_o, global_mask_o;
  logic entry_busy_o, mem_write_o, mem_read_o, handler_valid_o;
  logic [15:0] mem_addr_o, handler_addr_o;
  logic [4:0] vector_number_o;
  int n_fail = 0;
  int tests_run = 0;

  epi_top u_epi_top (.*);
  epi_partner u_epi_partner (.clk_i(ref_clk_i), .rd_i(mem_read_o),
    .addr_i(mem_addr_o), .drv_en_i(drv_en), .drv_val_i(drv_val),
    .pull_en_i(pull_enable_o), .pull_up_i(pull_up_o),
    .rdata_o(mem_rdata_i), .pin_o(ext_request_pin_i));

  always #5 ref_clk_i = !ref_clk_i;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic ack();
    flag_acknowledge_i = 1;
    tick(1);
    flag_acknowledge_i = 0;
    tick(1);
  endtask
  task automatic unmask();
    mask_clear_i = 1;
    tick(1);
    mask_clear_i = 0;
  endtask
  // handler word as the memory model lays it out, high byte first
  function automatic logic [15:0] hv(input logic [4:0] n);
    logic [15:0] a;
    a = 16'hfffe - {10'h000, n, 1'b0};
    hv = {a[7:0] ^ 8'h3c, a[7:0] ^ 8'h3d};
  endfunction
  // bounded wait for the handler fetch to finish
  task automatic entry(input logic [4:0] n);
    int i;
    i = 0;
    instr_boundary_i = 1;
    while (handler_valid_o !== 1'b1 && i < 40)
    begin
      tick(1);
      i++;
    end
    if (i == 40)
    begin
      n_fail++;
      conclude();
    end
    instr_boundary_i = 0;
    chk(vector_number_o, n);
    chk(handler_addr_o, hv(n));
    chk(global_mask_o, 1'b1);
    tick(1);
  endtask

  initial
  begin
    tick(6);
    reset_n_i = 1;
    entry(5'h00);
    $display("test reset_fetch done");
    ext_request_pin_enable_i = 1;
    tick(4);
    chk(pull_enable_o, 1'b1);
    chk(pull_up_o, 1'b1);
    // the pin floated before the pull came on; drop any stray event
    ack();
    chk(pin_event_flag_o, 1'b0);
    drv_en = 1;
    tick(4);
    chk(pin_event_flag_o, 1'b1);
    chk(pin_irq_o, 1'b0);
    chk(branch_if_pin_low_o, 1'b1);
    ack();
    chk(pin_event_flag_o, 1'b0);
    pin_interrupt_enable_i = 1;
    drv_val = 1;
    tick(4);
    drv_val = 0;
    tick(4);
    chk(pin_irq_o, 1'b1);
    detect_mode_select_i = 1;
    ack();
    chk(pin_event_flag_o, 1'b1);
    $display("test pin_edge_level done");
    // lowv and a timer source pending beside the pin
    source_flag_i = 32'h24;
    source_enable_i = 32'hffffffff;
    unmask();
    entry(5'h02);
    source_flag_i = 32'h20;
    unmask();
    entry(5'h03);
    instr_boundary_i = 1;
    tick(12);
    chk(entry_busy_o, 1'b0);
    software_trap_i = 1;
    tick(1);
    software_trap_i = 0;
    entry(5'h01);
    $display("test vectoring done");
    drv_en = 0;
    tick(4);
    ack();
    chk(pin_event_flag_o, 1'b0);
    pull_device_disable_i = 1;
    tick(2);
    chk(pull_enable_o, 1'b0);
    pull_device_disable_i = 0;
    edge_polarity_select_i = 1;
    detect_mode_select_i = 0;
    drv_en = 1;
    tick(2);
    chk(pull_up_o, 1'b0);
    // the unpulled float may have left an event behind
    ack();
    chk(pin_event_flag_o, 1'b0);
    drv_val = 1;
    tick(4);
    chk(pin_event_flag_o, 1'b1);
    chk(branch_if_pin_high_o, 1'b1);
    stop_mode_i = 1;
    tick(2);
    chk(wake_o, 1'b1);
    stop_mode_i = 0;
    ack();
    ext_request_pin_enable_i = 0;
    drv_val = 0;
    tick(2);
    drv_val = 1;
    tick(4);
    chk(pin_event_flag_o, 1'b0);
    chk(branch_if_pin_high_o, 1'b0);
    $display("test polarity_disable done");
    // software mask control, then a reset in mid-run must mask again
    unmask();
    chk(global_mask_o, 1'b0);
    mask_set_i = 1;
    tick(1);
    mask_set_i = 0;
    chk(global_mask_o, 1'b1);
    unmask();
    chk(global_mask_o, 1'b0);
    reset_n_i = 0;
    tick(2);
    reset_n_i = 1;
    entry(5'h00);
    $display("test mid_reset done");
    conclude();
  end

  // hang guard
  initial
  begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule

`default_nettype wire
